/* rtl/trace_capture_pkg.sv */
// Operation
// RQ1: Port width selectable one to four lines, default four.
// RQ2: Sample trace data on both trace clock edges.
// RQ3: Two nibbles per trace period form one byte.
// RQ4: Trace clock asynchronous; synchronise before use.
// RQ5: Buffered mode wraps, overwriting oldest entries.
// RQ6: Buffer readback only while target halted.
// RQ7: Streaming mode forwards bytes continuously, unbounded.
// RQ8: Adjustable sample delay after each clock edge.
// RQ9: Source defaults to pins; may select on-chip. There is no on-chip trace input here, so selecting it only stops capture.
// RQ10: On-chip source disables streaming mode.
// RQ11: Rising-edge nibble low, falling-edge nibble high.
package trace_capture_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_RDIDX = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RDDATA = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_STREAM = 6'h10;
  localparam int unsigned BUF_AW = 8;
  localparam int unsigned BUF_DEPTH = 256;
  localparam logic [2:0] WIDTH_RESET = 3'h4;
  localparam logic [3:0] DELAY_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_WIDTH_LSB = 0;
  localparam int unsigned CTRL_DELAY_LSB = 4;
  localparam int unsigned CTRL_STREAM_BIT = 8;
  localparam int unsigned CTRL_SOURCE_BIT = 9;
  localparam int unsigned CTRL_ENABLE_BIT = 10;
  typedef enum logic {SRC_PINS, SRC_ONCHIP} capture_source_t;
  typedef struct packed {
    logic enable;
    capture_source_t capture_source_select;
    logic stream_mode;
    logic [3:0] sample_delay_setting;
    logic [2:0] port_width_setting;
  } ctrl_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } trace_byte_t;
endpackage

/* rtl/trace_port_capture.sv */
// The address map and register access over AXI4-Lite were decided locally.
module trace_port_capture (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic trace_port_clock_i,
  input wire logic [3:0] trace_data_lines_i,
  input wire logic target_halted_i,
  input wire logic [trace_capture_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [trace_capture_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [7:0] stream_data_o,
  output logic stream_valid_o
);
  trace_capture_pkg::ctrl_t ctrl;
  logic [1:0] clk_sync;
  logic clk_prev;
  logic [3:0] data_sync0;
  logic [3:0] data_sync1;
  logic [1:0] halt_sync;
  logic [3:0] dly_cnt;
  logic dly_busy;
  logic dly_rise;
  logic [3:0] low_nib;
  logic have_low;
  trace_capture_pkg::trace_byte_t cap;
  logic [7:0] buf_mem [trace_capture_pkg::BUF_DEPTH];
  logic [trace_capture_pkg::BUF_AW-1:0] wr_ptr;
  logic wrapped;
  logic [trace_capture_pkg::BUF_AW-1:0] rd_idx;
  logic [31:0] stream_count;
  logic aw_held;
  logic w_held;
  logic [trace_capture_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic edge_rise;
  logic edge_fall;
  logic buffered_on;
  logic streaming_on;

  function automatic logic [3:0] width_mask(input logic [2:0] w);
    logic [3:0] m;
    m = 4'h0;
    case (w)
      3'h1: m = 4'h1;
      3'h2: m = 4'h3;
      3'h3: m = 4'h7;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Trace clock and data are asynchronous and pass two flops first. [RQ4]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_sync <= 2'h0;
      clk_prev <= 1'b0;
      data_sync0 <= 4'h0;
      data_sync1 <= 4'h0;
      halt_sync <= 2'h0;
    end else begin
      clk_sync <= {clk_sync[0], trace_port_clock_i}; // [RQ4]
      clk_prev <= clk_sync[1];
      data_sync0 <= trace_data_lines_i;
      data_sync1 <= data_sync0;
      halt_sync <= {halt_sync[0], target_halted_i};
    end
  end

  assign edge_rise = clk_sync[1] && !clk_prev;
  assign edge_fall = !clk_sync[1] && clk_prev;
  // On-chip source leaves pin capture and streaming idle. [RQ9] [RQ10]
  assign buffered_on = ctrl.enable && ctrl.capture_source_select == trace_capture_pkg::SRC_PINS
    && !ctrl.stream_mode;
  assign streaming_on = ctrl.enable && ctrl.capture_source_select == trace_capture_pkg::SRC_PINS
    && ctrl.stream_mode; // [RQ10]

  // The sample point trails each clock edge by the programmed delay. A delay longer than half
  // a trace period loses the edge, so software must keep it short. [RQ8]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_cnt <= 4'h0;
      dly_busy <= 1'b0;
      dly_rise <= 1'b0;
    end else if (edge_rise || edge_fall) begin
      dly_cnt <= ctrl.sample_delay_setting; // [RQ8]
      dly_busy <= 1'b1;
      dly_rise <= edge_rise;
    end else if (dly_busy && dly_cnt != 4'h0) begin
      dly_cnt <= dly_cnt - 4'h1;
    end else begin
      dly_busy <= 1'b0;
    end
  end

  logic sample_now;
  assign sample_now = dly_busy && dly_cnt == 4'h0;

  // Sample on both edges and pair nibbles into bytes. [RQ2] [RQ3]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_nib <= 4'h0;
      have_low <= 1'b0;
      cap <= '0;
    end else begin
      cap.valid <= 1'b0;
      if (sample_now && (buffered_on || streaming_on)) begin
        if (dly_rise) begin
          low_nib <= data_sync1 & width_mask(ctrl.port_width_setting); // [RQ11]
          have_low <= 1'b1;
        end else if (have_low) begin
          cap.data <= {data_sync1 & width_mask(ctrl.port_width_setting), low_nib}; // [RQ3] [RQ11]
          cap.valid <= 1'b1; // [RQ2]
          have_low <= 1'b0;
        end
      end else if (!(buffered_on || streaming_on)) begin
        have_low <= 1'b0;
      end
    end
  end

  // Circular store that overwrites the oldest byte once full. [RQ5]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      wrapped <= 1'b0;
    end else if (cap.valid && buffered_on) begin
      wr_ptr <= wr_ptr + 1'b1; // [RQ5]
      if (wr_ptr == trace_capture_pkg::BUF_AW'(trace_capture_pkg::BUF_DEPTH - 1)) begin
        wrapped <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (cap.valid && buffered_on) begin
      buf_mem[wr_ptr] <= cap.data;
    end
  end

  // Streaming has no local store; every byte leaves at once. [RQ7]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stream_data_o <= 8'h00;
      stream_valid_o <= 1'b0;
      stream_count <= 32'h0;
    end else begin
      stream_valid_o <= cap.valid && streaming_on; // [RQ7]
      if (cap.valid && streaming_on) begin
        stream_data_o <= cap.data;
        stream_count <= stream_count + 32'h1;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order, then one response.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= trace_capture_pkg::RESP_OKAY;
      ctrl <= '{enable: 1'b0, capture_source_select: trace_capture_pkg::SRC_PINS,
        stream_mode: 1'b0, sample_delay_setting: trace_capture_pkg::DELAY_RESET,
        port_width_setting: trace_capture_pkg::WIDTH_RESET}; // [RQ1] [RQ9]
      rd_idx <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
      if (aw_held && w_held && !bvalid_o) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= trace_capture_pkg::RESP_OKAY;
        case (aw_addr)
          trace_capture_pkg::OFS_CTRL: begin
            if (w_strb[0]) begin
              ctrl.port_width_setting <= (w_data[2:0] == 3'h0 || w_data[2:0] > 3'h4) ?
                trace_capture_pkg::WIDTH_RESET : w_data[2:0]; // [RQ1]
              ctrl.sample_delay_setting <= w_data[trace_capture_pkg::CTRL_DELAY_LSB +: 4];
            end
            if (w_strb[1]) begin
              ctrl.stream_mode <= w_data[trace_capture_pkg::CTRL_STREAM_BIT];
              ctrl.capture_source_select <=
                trace_capture_pkg::capture_source_t'(w_data[trace_capture_pkg::CTRL_SOURCE_BIT]);
              ctrl.enable <= w_data[trace_capture_pkg::CTRL_ENABLE_BIT];
            end
          end
          trace_capture_pkg::OFS_RDIDX: begin
            if (w_strb[0]) begin
              rd_idx <= w_data[trace_capture_pkg::BUF_AW-1:0];
            end
          end
          default: bresp_o <= trace_capture_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o = !w_held && !bvalid_o;

  // AXI4-Lite read; buffer data is refused unless the target is halted. [RQ6]
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0;
      rresp_o <= trace_capture_pkg::RESP_OKAY;
    end else if (rvalid_o) begin
      if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end else if (arvalid_i) begin
      rvalid_o <= 1'b1;
      rresp_o <= trace_capture_pkg::RESP_OKAY;
      rdata_o <= 32'h0;
      case (araddr_i)
        // Readback follows the write layout, so the packed struct order is not reused.
        trace_capture_pkg::OFS_CTRL:
          rdata_o <= {21'h0, ctrl.enable, ctrl.capture_source_select, ctrl.stream_mode,
            ctrl.sample_delay_setting, 1'b0, ctrl.port_width_setting};
        trace_capture_pkg::OFS_STAT:
          rdata_o <= {20'h0, halt_sync[1], wrapped, 2'h0, wr_ptr};
        trace_capture_pkg::OFS_RDIDX: rdata_o <= {24'h0, rd_idx};
        trace_capture_pkg::OFS_RDDATA: begin
          if (halt_sync[1]) begin
            rdata_o <= {24'h0, buf_mem[rd_idx]}; // [RQ6]
          end else begin
            rresp_o <= trace_capture_pkg::RESP_SLVERR; // [RQ6]
          end
        end
        trace_capture_pkg::OFS_STREAM: rdata_o <= stream_count;
        default: rresp_o <= trace_capture_pkg::RESP_SLVERR;
      endcase
    end
  end

  assign arready_o = !rvalid_o;

  a_width_default: assert property (@(posedge clk_sys_i) $rose(resetn_i) |->
    ctrl.port_width_setting == 3'h4) else $error("width not four after reset"); // [RQ1]
  a_byte_pairs: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cap.valid |-> $past(sample_now) && !$past(dly_rise)) else $error("byte off fall"); // [RQ2]
  a_low_nibble: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cap.valid |-> cap.data[3:0] == $past(low_nib)) else $error("low nibble wrong"); // [RQ11]
  a_wrap_ptr: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cap.valid && buffered_on |=> wr_ptr == $past(wr_ptr) + 8'h1) else $error("no advance"); // [RQ5]
  a_halt_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    arvalid_i && arready_o && araddr_i == trace_capture_pkg::OFS_RDDATA && !halt_sync[1]
    |=> rresp_o == trace_capture_pkg::RESP_SLVERR) else $error("read while running"); // [RQ6]
  a_stream_out: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    cap.valid && streaming_on |=> stream_valid_o && stream_data_o == $past(cap.data))
    else $error("stream byte lost"); // [RQ7]
  a_onchip_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ctrl.capture_source_select == trace_capture_pkg::SRC_ONCHIP [*2] |-> !stream_valid_o)
    else $error("stream with on-chip source"); // [RQ10]
  a_delay_point: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    edge_rise && ctrl.sample_delay_setting == 4'h2 && !edge_fall |=> !sample_now [*2])
    else $error("sampled too early"); // [RQ8]
  a_source_default: assert property (@(posedge clk_sys_i) $rose(resetn_i) |->
    ctrl.capture_source_select == trace_capture_pkg::SRC_PINS) else $error("bad source"); // [RQ9]
  a_sync_flow: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    edge_rise |-> $past(clk_sync[0]) && !$past(clk_sync[0], 2)) else $error("edge without sync"); // [RQ4]

  c_stream: cover property (@(posedge clk_sys_i) stream_valid_o);
  c_wrap: cover property (@(posedge clk_sys_i) $rose(wrapped));
  c_halt_read: cover property (@(posedge clk_sys_i) rvalid_o && rresp_o == 2'h0 && halt_sync[1]);
endmodule

/* tb/trace_source_model.sv */
module trace_source_model (
  input wire logic zero_setup_i,
  output logic trace_port_clock_o,
  output logic [3:0] trace_data_lines_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    trace_port_clock_o = 1'b0;
    trace_data_lines_o = 4'hA;
  end

  // One byte per 160 ns trace period, a new nibble on each clock edge.
  task automatic send_byte(input logic [7:0] b);
    if (zero_setup_i) begin
      // Data changes together with the edge, leaving no setup time.
      trace_data_lines_o = b[3:0];
      trace_port_clock_o = 1'b1;
      #80;
      trace_data_lines_o = b[7:4];
      trace_port_clock_o = 1'b0;
      #80;
    end else begin
      trace_data_lines_o = b[3:0];
      #40;
      trace_port_clock_o = 1'b1;
      #40;
      trace_data_lines_o = b[7:4];
      #40;
      trace_port_clock_o = 1'b0;
      #40;
    end
    // Hold time is over, so the lines no longer show the last nibble.
    trace_data_lines_o = ~trace_data_lines_o;
  endtask
endmodule

/* tb/trace_port_capture_tb.sv */
module trace_port_capture_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic halted = 1'b0;
  logic zero_setup = 1'b0;
  logic trace_clk;
  logic [3:0] trace_data;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, stream_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [7:0] stream_data;
  logic [7:0] got[$];
  logic [7:0] pat[8] = '{8'h3C, 8'hA5, 8'h0F, 8'hF0, 8'h5A, 8'h81, 8'h7E, 8'h12};
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  trace_source_model src_u (.zero_setup_i(zero_setup), .trace_port_clock_o(trace_clk),
    .trace_data_lines_o(trace_data));

  trace_port_capture dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .trace_port_clock_i(trace_clk), .trace_data_lines_i(trace_data),
    .target_halted_i(halted), .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
    .bvalid_o(bvalid), .bready_i(1'b1), .araddr_i(araddr), .arvalid_i(arvalid),
    .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
    .rready_i(1'b1), .stream_data_o(stream_data), .stream_valid_o(stream_valid));

  always @(posedge clk_sys_i) begin
    if (stream_valid === 1'b1) got.push_back(stream_data);
    cycles++;
    if (cycles == 60000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_sys_i);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys_i); while (bvalid !== 1'b1);
    check(32'(bresp), 32'(trace_capture_pkg::RESP_OKAY));
  endtask

  task automatic axi_read(input logic [5:0] a, input logic [1:0] exp_resp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid !== 1'b1);
    rd = rdata;
    check(32'(rresp), 32'(exp_resp));
  endtask

  task automatic stream_case(input logic [31:0] ctrl, input logic zs, input logic [7:0] mask,
                             input bit on);
    axi_write(trace_capture_pkg::OFS_CTRL, ctrl);
    zero_setup <= zs;
    repeat (10) @(posedge clk_sys_i);
    got.delete();
    foreach (pat[i]) begin
      #7;
      src_u.send_byte(pat[i]);
    end
    repeat (12) @(posedge clk_sys_i);
    check(32'(got.size()), on ? 32'd8 : 32'd0);
    if (on) foreach (got[i]) check(32'(got[i]), 32'(pat[i] & mask));
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    axi_read(trace_capture_pkg::OFS_CTRL, trace_capture_pkg::RESP_OKAY);
    check(rd & 32'h0000_07FF, 32'h0000_0004);
    axi_read(6'h3C, trace_capture_pkg::RESP_SLVERR);
    $display("test reset_and_map done");
    stream_case(32'h0000_0504, 1'b0, 8'hFF, 1'b1);
    stream_case(32'h0000_0524, 1'b1, 8'hFF, 1'b1);
    stream_case(32'h0000_0501, 1'b0, 8'h11, 1'b1);
    stream_case(32'h0000_0704, 1'b0, 8'hFF, 1'b0);
    axi_read(trace_capture_pkg::OFS_STREAM, trace_capture_pkg::RESP_OKAY);
    check(rd, 32'h0000_0018);
    $display("test streaming done");
    axi_write(trace_capture_pkg::OFS_CTRL, 32'h0000_0404);
    axi_read(trace_capture_pkg::OFS_CTRL, trace_capture_pkg::RESP_OKAY);
    check(rd, 32'h0000_0404);
    repeat (10) @(posedge clk_sys_i);
    for (int i = 0; i < 260; i++) begin
      #7;
      src_u.send_byte(8'(i) ^ ((i >= 256) ? 8'h5A : 8'hA5));
    end
    repeat (12) @(posedge clk_sys_i);
    axi_read(trace_capture_pkg::OFS_RDDATA, trace_capture_pkg::RESP_SLVERR);
    check(rd, 32'h0000_0000);
    halted <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    axi_read(trace_capture_pkg::OFS_STAT, trace_capture_pkg::RESP_OKAY);
    check(rd & 32'h0000_0CFF, 32'h0000_0C04);
    foreach (pat[k]) begin
      axi_write(trace_capture_pkg::OFS_RDIDX, 32'(pat[k]) & 32'h0000_0007);
      axi_read(trace_capture_pkg::OFS_RDDATA, trace_capture_pkg::RESP_OKAY);
      check(rd & 32'h0000_00FF, 32'((8'(pat[k] & 8'h07) + 8'h00) ^ 8'hA5) ^
            (((pat[k] & 8'h07) < 8'h04) ? 32'h0000_00FF : 32'h0000_0000));
    end
    $display("test buffered done");
    results();
  end
endmodule
